// [hdl/flow_scaling_defines.svh]
// Offsets, field positions, reset values and counts of the flow scaling block.
`ifndef FLOW_SCALING_DEFINES_SVH
`define FLOW_SCALING_DEFINES_SVH
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_KFACTOR   8'h08
`define OFF_KF_SET    8'h0C
`define OFF_CAL_VOL   8'h10
`define OFF_FLOW_SET  8'h14
`define OFF_LOW_MA    8'h18
`define OFF_LOW_FLOW  8'h1C
`define OFF_HIGH_MA   8'h20
`define OFF_HIGH_FLOW 8'h24
`define OFF_VOUT_MIN  8'h28
`define OFF_VOUT_MAX  8'h2C
`define OFF_INJ_EN    8'h30
`define OFF_FLOW_ACT  8'h34
`define OFF_MAX_FLOW  8'h38
`define OFF_VOUT      8'h3C
`define OFF_CURRENT   8'h40
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT  1
`define CTRL_CFG_LSB   2
`define CTRL_CFG_MSB   8
`define MODE_FLOW      2'h0
`define CAL_CYCLES     3'h5
`define MAX_CPM        16'h003C
`define INJ_POINTS     8
`define KF_RST         16'h0001
`define LOW_MA_RST     16'h0FA0
`define HIGH_MA_RST    16'h4E20
`define VOUT_MIN_RST   16'h0000
`define VOUT_MAX_RST   16'h1388
`endif

// [hdl/flow_scaling_pkg.sv]
// Types shared by the flow scaling block.
package flow_scaling_pkg;
   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_RUN,
      CAL_ENTRY
   } cal_state_type;

   typedef struct packed {
      logic       multi_point_injection;
      logic       vsp;
      logic [1:0] mode;
      logic       metric;
      logic       aout_en;
      logic       ain_en;
   } ctrl_type;
endpackage : flow_scaling_pkg

// [hdl/flow_scaling_and_calibration.sv]
// Volume factor calibration, current-loop flow scaling and speed output.
// What this block does
// RL1: Start begins pumping at once.
// RL2: Run ends on stop or five cycles.
// RL3: Volume entry accepted only after cycles finish.
// RL4: Entered volume sets new factor, overriding others.
// RL5: Factor register itself is read-only.
// RL6: Loop current interpolated linearly into flow.
// RL7: Below lower point gives lower flow.
// RL8: Above upper point gives upper flow.
// RL9: Loop input acts only in flow mode.
// RL10: Manual setpoint locked while loop input on.
// RL11: Same rate to every enabled injection point.
// RL12: Maximum flow derived from factor.
// RL13: Fixed setpoint scales output between floor, ceiling.
// RL14: Output recomputed continuously from loop flow.
// RL15: Output never outside floor and ceiling unless ceiling is set below floor.
// RL16: Speed output acts only in flow mode.
// RL17: Ceiling output during speed-pump calibration while aout_en is clear.
// RL18: Operator avoids settings below stall voltage.
// RL19: Unit selection stored and driven out.
// RL20: Equal current points give lower flow.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "flow_scaling_defines.svh"
module flow_scaling_and_calibration (
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave.
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Pump side.
   input  wire logic                  cycle_switch,
   input  wire logic [15:0]           loop_current,
   output logic                       pump_run,
   output logic      [15:0]           speed_code,
   // Results.
   output logic                       metric_units,
   output logic      [15:0]           flow_setpoint,
   output logic [`INJ_POINTS-1:0][15:0] inj_rate
);
   flow_scaling_pkg::cal_state_type state_reg, state_next;
   flow_scaling_pkg::ctrl_type      ctrl_reg, ctrl_next;
   logic [2:0]  cnt_reg, cnt_next;
   logic [15:0] kf_reg, kf_next, vol_reg, vol_next, fset_reg, fset_next;
   logic [15:0] lma_reg, lma_next, lfl_reg, lfl_next;
   logic [15:0] hma_reg, hma_next, hfl_reg, hfl_next;
   logic [15:0] vmin_reg, vmin_next, vmax_reg, vmax_next;
   logic [`INJ_POINTS-1:0] inj_en_reg, inj_en_next;
   logic [31:0] rd_reg, rd_next;
   logic        err_reg, err_next;
   logic        sw_meta, sw_sync, sw_prev, cyc_edge;
   logic        wr_en, wr_ctrl, ain_act, aout_act;
   logic [15:0] flow_reg, flow_next, spd_reg, spd_next;
   logic [`INJ_POINTS-1:0][15:0] inj_reg, inj_next;
   logic [15:0] ain_flow, cur_off, span_ma, span_v;
   logic signed [16:0] dflow;
   logic signed [33:0] prod, quot;
   logic [31:0] max_flow, prod_v, quot_v;

   // The switch is asynchronous to pclk, so it is synchronised first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
         sw_prev <= 1'b0;
      end else begin
         sw_meta <= cycle_switch;
         sw_sync <= sw_meta;
         sw_prev <= sw_sync;
      end
   end
   assign cyc_edge = sw_sync & ~sw_prev;

   assign wr_en    = psel & penable & pwrite;
   assign wr_ctrl  = wr_en && paddr == `OFF_CTRL;
   assign ain_act  = ctrl_reg.ain_en && ctrl_reg.mode == `MODE_FLOW; // RL9
   assign aout_act = ctrl_reg.aout_en && ctrl_reg.mode == `MODE_FLOW; // RL16
   assign pready   = 1'b1;
   assign pslverr  = err_reg;
   assign prdata   = rd_reg;

   always_comb begin
      state_next  = state_reg;
      ctrl_next   = ctrl_reg;
      cnt_next    = cnt_reg;
      kf_next     = kf_reg;
      vol_next    = vol_reg;
      fset_next   = fset_reg;
      lma_next    = lma_reg;
      lfl_next    = lfl_reg;
      hma_next    = hma_reg;
      hfl_next    = hfl_reg;
      vmin_next   = vmin_reg;
      vmax_next   = vmax_reg;
      inj_en_next = inj_en_reg;
      if (wr_en) begin
         case (paddr)
            `OFF_CTRL:      ctrl_next = pwdata[`CTRL_CFG_MSB:`CTRL_CFG_LSB];
            `OFF_KF_SET:    kf_next = pwdata[15:0];
            `OFF_FLOW_SET:  if (!ain_act) fset_next = pwdata[15:0]; // RL10
            `OFF_LOW_MA:    lma_next = pwdata[15:0];
            `OFF_LOW_FLOW:  lfl_next = pwdata[15:0];
            `OFF_HIGH_MA:   hma_next = pwdata[15:0];
            `OFF_HIGH_FLOW: hfl_next = pwdata[15:0];
            `OFF_VOUT_MIN:  vmin_next = pwdata[15:0];
            `OFF_VOUT_MAX:  vmax_next = pwdata[15:0];
            `OFF_INJ_EN:    inj_en_next = pwdata[`INJ_POINTS-1:0];
            default:        ;
         endcase
      end
      case (state_reg)
         flow_scaling_pkg::CAL_IDLE,
         flow_scaling_pkg::CAL_ENTRY: begin
            if (wr_ctrl && pwdata[`CTRL_START_BIT]) begin
               state_next = flow_scaling_pkg::CAL_RUN; // RL1
               cnt_next   = 3'h0;
            end else if (state_reg == flow_scaling_pkg::CAL_ENTRY &&
                         wr_en && paddr == `OFF_CAL_VOL) begin
               vol_next   = pwdata[15:0]; // RL3
               kf_next    = pwdata[15:0] / `CAL_CYCLES; // RL4
               state_next = flow_scaling_pkg::CAL_IDLE;
            end
         end
         flow_scaling_pkg::CAL_RUN: begin
            if (wr_ctrl && pwdata[`CTRL_STOP_BIT]) begin
               state_next = flow_scaling_pkg::CAL_IDLE; // RL2
            end else if (cyc_edge) begin
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg + 3'h1 == `CAL_CYCLES) begin
                  state_next = flow_scaling_pkg::CAL_ENTRY; // RL2
               end
            end
         end
         default: state_next = flow_scaling_pkg::CAL_IDLE;
      endcase
   end

   // Reads are captured in the setup phase so prdata comes from a flop
   // and the slave can still answer with no wait state.
   always_comb begin
      rd_next  = rd_reg;
      err_next = err_reg;
      if (psel && !penable) begin
         err_next = 1'b0;
         case (paddr)
            `OFF_CTRL:      rd_next = {23'h00_0000, ctrl_reg, 2'h0};
            `OFF_STATUS:    rd_next = {27'h000_0000, cnt_reg,
                                       state_reg == flow_scaling_pkg::CAL_ENTRY,
                                       state_reg == flow_scaling_pkg::CAL_RUN};
            `OFF_KFACTOR,
            `OFF_KF_SET:    rd_next = {16'h0000, kf_reg}; // RL5
            `OFF_CAL_VOL:   rd_next = {16'h0000, vol_reg};
            `OFF_FLOW_SET:  rd_next = {16'h0000, fset_reg};
            `OFF_LOW_MA:    rd_next = {16'h0000, lma_reg};
            `OFF_LOW_FLOW:  rd_next = {16'h0000, lfl_reg};
            `OFF_HIGH_MA:   rd_next = {16'h0000, hma_reg};
            `OFF_HIGH_FLOW: rd_next = {16'h0000, hfl_reg};
            `OFF_VOUT_MIN:  rd_next = {16'h0000, vmin_reg};
            `OFF_VOUT_MAX:  rd_next = {16'h0000, vmax_reg};
            `OFF_INJ_EN:    rd_next = {24'h00_0000, inj_en_reg};
            `OFF_FLOW_ACT:  rd_next = {16'h0000, flow_reg};
            `OFF_MAX_FLOW:  rd_next = max_flow;
            `OFF_VOUT:      rd_next = {16'h0000, spd_reg};
            `OFF_CURRENT:   rd_next = {16'h0000, loop_current};
            default: begin
               rd_next  = 32'h0000_0000;
               err_next = 1'b1;
            end
         endcase
      end
   end

   // Flow and speed are recomputed every cycle; the dividers are wide
   // combinational paths traded for zero latency.
   always_comb begin
      cur_off = loop_current - lma_reg;
      span_ma = hma_reg - lma_reg;
      dflow   = $signed({1'b0, hfl_reg}) - $signed({1'b0, lfl_reg});
      prod    = $signed({1'b0, cur_off}) * dflow;
      quot    = (span_ma == 16'h0000) ? 34'sh0_0000_0000 :
                prod / $signed({18'h0_0000, span_ma});
      if (hma_reg <= lma_reg) begin
         ain_flow = lfl_reg; // RL20
      end else if (loop_current <= lma_reg) begin
         ain_flow = lfl_reg; // RL7
      end else if (loop_current >= hma_reg) begin
         ain_flow = hfl_reg; // RL8
      end else begin
         ain_flow = lfl_reg + quot[15:0]; // RL6
      end
      flow_next = ain_act ? ain_flow : fset_reg; // RL14
      max_flow  = kf_reg * `MAX_CPM; // RL12
      span_v    = (vmax_reg > vmin_reg) ? vmax_reg - vmin_reg : 16'h0000;
      prod_v    = flow_next * span_v;
      quot_v    = (max_flow == 32'h0000_0000) ? 32'h0000_0000 : prod_v / max_flow;
      if (state_reg == flow_scaling_pkg::CAL_RUN && ctrl_reg.vsp &&
          !ctrl_reg.aout_en) begin
         spd_next = vmax_reg; // RL17
      end else if (!aout_act) begin
         spd_next = vmin_reg;
      end else if (quot_v >= {16'h0000, span_v}) begin
         spd_next = (vmax_reg > vmin_reg) ? vmax_reg : vmin_reg; // RL15
      end else begin
         spd_next = vmin_reg + quot_v[15:0]; // RL13
      end
   end

   for (genvar i = 0; i < `INJ_POINTS; i++) begin : g_inj
      // With multi-point injection every enabled point gets the one shared rate; otherwise point 0 alone.
      assign inj_next[i] = (ctrl_reg.multi_point_injection ? inj_en_reg[i] : i == 0) ?
                           flow_next : 16'h0000; // RL11
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= flow_scaling_pkg::CAL_IDLE;
         ctrl_reg   <= '0;
         cnt_reg    <= 3'h0;
         kf_reg     <= `KF_RST;
         vol_reg    <= 16'h0000;
         fset_reg   <= 16'h0000;
         lma_reg    <= `LOW_MA_RST;
         lfl_reg    <= 16'h0000;
         hma_reg    <= `HIGH_MA_RST;
         hfl_reg    <= 16'h0000;
         vmin_reg   <= `VOUT_MIN_RST;
         vmax_reg   <= `VOUT_MAX_RST;
         inj_en_reg <= '0;
         rd_reg     <= 32'h0000_0000;
         err_reg    <= 1'b0;
         flow_reg   <= 16'h0000;
         spd_reg    <= `VOUT_MIN_RST;
         inj_reg    <= '0;
      end else begin
         state_reg  <= state_next;
         ctrl_reg   <= ctrl_next;
         cnt_reg    <= cnt_next;
         kf_reg     <= kf_next;
         vol_reg    <= vol_next;
         fset_reg   <= fset_next;
         lma_reg    <= lma_next;
         lfl_reg    <= lfl_next;
         hma_reg    <= hma_next;
         hfl_reg    <= hfl_next;
         vmin_reg   <= vmin_next;
         vmax_reg   <= vmax_next;
         inj_en_reg <= inj_en_next;
         rd_reg     <= rd_next;
         err_reg    <= err_next;
         flow_reg   <= flow_next;
         spd_reg    <= spd_next;
         inj_reg    <= inj_next;
      end
   end

   assign pump_run      = state_reg == flow_scaling_pkg::CAL_RUN;
   assign metric_units  = ctrl_reg.metric; // RL19
   assign flow_setpoint = flow_reg;
   assign speed_code    = spd_reg;
   assign inj_rate      = inj_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_start_runs;
      !pump_run && wr_ctrl && pwdata[`CTRL_START_BIT] |=> pump_run;
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("start did not run pump"); // RL1

   // A stop abandons the run without opening volume entry, whatever the count.
   property p_stop_ends;
      pump_run && wr_ctrl && pwdata[`CTRL_STOP_BIT] |=>
         !pump_run && state_reg == flow_scaling_pkg::CAL_IDLE;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("stop did not end run"); // RL2

   property p_five_cycles;
      pump_run && cyc_edge && cnt_reg == 3'h4 && !wr_ctrl |=>
         state_reg == flow_scaling_pkg::CAL_ENTRY && !pump_run;
   endproperty
   a_five_cycles: assert property (p_five_cycles) else $error("run not ended at count"); // RL2

   property p_entry_gate;
      wr_en && paddr == `OFF_CAL_VOL && state_reg != flow_scaling_pkg::CAL_ENTRY
         |=> $stable(kf_reg) && $stable(vol_reg);
   endproperty
   a_entry_gate: assert property (p_entry_gate) else $error("volume taken outside entry"); // RL3

   property p_kf_update;
      wr_en && paddr == `OFF_CAL_VOL && state_reg == flow_scaling_pkg::CAL_ENTRY
         |=> kf_reg == $past(pwdata[15:0]) / `CAL_CYCLES ##1 !pump_run;
   endproperty
   a_kf_update: assert property (p_kf_update) else $error("factor not derived"); // RL4

   property p_clamp_low;
      ain_act && hma_reg > lma_reg && loop_current <= lma_reg |=> flow_reg == $past(lfl_reg);
   endproperty
   a_clamp_low: assert property (p_clamp_low) else $error("low clamp wrong"); // RL7

   property p_clamp_high;
      ain_act && hma_reg > lma_reg && loop_current >= hma_reg |=> flow_reg == $past(hfl_reg);
   endproperty
   a_clamp_high: assert property (p_clamp_high) else $error("high clamp wrong"); // RL8

   property p_equal_points;
      ain_act && hma_reg == lma_reg |=> flow_reg == $past(lfl_reg);
   endproperty
   a_equal_points: assert property (p_equal_points) else $error("equal points wrong"); // RL20

   property p_set_locked;
      wr_en && paddr == `OFF_FLOW_SET && ain_act |=> $stable(fset_reg);
   endproperty
   a_set_locked: assert property (p_set_locked) else $error("setpoint changed"); // RL10

   // Limits are taken from the cycle that computed the code, since a write may move them.
   property p_out_range;
      aout_act && vmax_reg >= vmin_reg |=>
         spd_reg >= $past(vmin_reg) && spd_reg <= $past(vmax_reg);
   endproperty
   a_out_range: assert property (p_out_range) else $error("speed out of range"); // RL15

   property p_cal_full;
      pump_run && ctrl_reg.vsp && !ctrl_reg.aout_en |=> spd_reg == $past(vmax_reg);
   endproperty
   a_cal_full: assert property (p_cal_full) else $error("no full speed in calibration"); // RL17

   property p_same_rate;
      $past(ctrl_reg.multi_point_injection) && $past(inj_en_reg[1]) |-> inj_reg[1] == flow_reg;
   endproperty
   a_same_rate: assert property (p_same_rate) else $error("point rate differs"); // RL11

   property p_single_point;
      !ctrl_reg.multi_point_injection |=> inj_reg[1] == 16'h0000 && inj_reg[0] == flow_reg;
   endproperty
   a_single_point: assert property (p_single_point) else $error("single point wrong"); // RL11

   property p_count_bound;
      pump_run |-> cnt_reg < `CAL_CYCLES;
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("run outlived its count"); // RL2

   property p_entry_holds;
      state_reg == flow_scaling_pkg::CAL_ENTRY && !wr_en |=>
         state_reg == flow_scaling_pkg::CAL_ENTRY && !pump_run;
   endproperty
   a_entry_holds: assert property (p_entry_holds) else $error("entry closed early"); // RL3

   property p_factor_ro;
      wr_en && paddr == `OFF_KFACTOR |=> $stable(kf_reg);
   endproperty
   a_factor_ro: assert property (p_factor_ro) else $error("factor written directly"); // RL5

   property p_flow_manual;
      !ain_act |=> flow_reg == $past(fset_reg);
   endproperty
   a_flow_manual: assert property (p_flow_manual) else $error("loop flow outside mode"); // RL9

   // Outside a run, a disabled output parks at the floor, never below it.
   property p_speed_off;
      !aout_act && !pump_run |=> spd_reg == $past(vmin_reg);
   endproperty
   a_speed_off: assert property (p_speed_off) else $error("speed driven while off"); // RL16

   c_cal_entry: cover property (pump_run ##[1:1000] state_reg == flow_scaling_pkg::CAL_ENTRY);
   c_interp: cover property (ain_act && loop_current > lma_reg && loop_current < hma_reg);
   c_speed_mid: cover property (aout_act && spd_reg > vmin_reg && spd_reg < vmax_reg);
   c_stop_abort: cover property (pump_run && wr_ctrl && pwdata[`CTRL_STOP_BIT]);
   c_clamp_high: cover property (ain_act && hma_reg > lma_reg && loop_current >= hma_reg);
endmodule : flow_scaling_and_calibration

// [sim/pump_side_model.sv]
// Behavioural pump and current-loop transmitter that face the flow scaling block.
module pump_side_model (
   // Clock.
   input  wire logic        pclk,
   // Pump motor side.
   input  wire logic        pump_run,
   input  wire logic        slow,
   output logic             cycle_switch,
   // Current-loop transmitter side.
   input  wire logic [15:0] level_ua,
   output logic      [15:0] loop_current
);
   timeunit 1ns;
   timeprecision 1ps;
   int tick;
   // The reed switch closes once a stroke, only while the motor turns; a slow pump strokes rarely.
   initial begin
      cycle_switch = 1'b0;
      tick = 0;
   end
   always @(posedge pclk) begin
      tick <= pump_run ? tick + 1 : 0;
      cycle_switch <= pump_run && ((tick % (slow ? 24 : 8)) >= 4);
   end
   // The transmitter follows the level set for it.
   assign loop_current = level_ua;
endmodule : pump_side_model

// [sim/flow_scaling_and_calibration_tb.sv]
// Self-checking bench for the flow scaling and calibration block.
`include "flow_scaling_defines.svh"
module flow_scaling_and_calibration_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                        pclk = 1'b0;
   logic                        presetn = 1'b0;
   logic                        psel = 1'b0;
   logic                        penable = 1'b0;
   logic                        pwrite = 1'b0;
   logic [7:0]                  paddr = 8'h00;
   logic [31:0]                 pwdata = 32'h0000_0000;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   logic                        cycle_switch;
   logic [15:0]                 loop_current;
   logic [15:0]                 level_ua = 16'h0000;
   logic                        slow = 1'b0;
   logic                        pump_run;
   logic [15:0]                 speed_code;
   logic                        metric_units;
   logic [15:0]                 flow_setpoint;
   logic [`INJ_POINTS-1:0][15:0] inj_rate;
   logic [31:0]                 q;
   logic                        err_seen;
   int                          fail_count = 0;
   int                          checks_done = 0;

   always #2.5 pclk = ~pclk;

   flow_scaling_and_calibration u_flow_scaling_and_calibration (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cycle_switch(cycle_switch), .loop_current(loop_current), .pump_run(pump_run),
      .speed_code(speed_code), .metric_units(metric_units), .flow_setpoint(flow_setpoint),
      .inj_rate(inj_rate));

   pump_side_model u_pump_side_model (
      .pclk(pclk), .pump_run(pump_run), .slow(slow), .cycle_switch(cycle_switch),
      .level_ua(level_ua), .loop_current(loop_current));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wait_cycles

   task automatic reset_values;
      apb(0, `OFF_KFACTOR, 0); check(q, 32'h0000_0001);
      apb(0, `OFF_LOW_MA, 0); check(q, 32'h0000_0FA0);
      apb(0, `OFF_HIGH_MA, 0); check(q, 32'h0000_4E20);
      apb(0, `OFF_VOUT_MAX, 0); check(q, 32'h0000_1388);
      apb(0, 8'hF0, 0); check({q[30:0], err_seen}, 32'h0000_0001);
   endtask : reset_values

   task automatic calibrate;
      int n;
      slow <= 1'b1;
      apb(1, `OFF_CTRL, 32'h0000_0081);
      wait_cycles(1);
      check(pump_run, 1'b1);
      check(speed_code, 32'h0000_1388);
      apb(1, `OFF_CAL_VOL, 32'h0000_01F4);
      apb(0, `OFF_STATUS, 0); check(q[1], 1'b0);
      apb(0, `OFF_CAL_VOL, 0);
      check(q, 32'h0000_0000);
      n = 0;
      do begin
         apb(0, `OFF_STATUS, 0);
         n++;
      end while (q[1] !== 1'b1 && n < 200);
      check(q[1:0], 32'h0000_0002);
      apb(1, `OFF_KF_SET, 32'h0000_0007);
      apb(1, `OFF_CAL_VOL, 32'h0000_01F4);
      apb(0, `OFF_KFACTOR, 0); check(q, 32'h0000_0064);
      apb(1, `OFF_KFACTOR, 32'h0000_0009);
      apb(0, `OFF_KFACTOR, 0); check(q, 32'h0000_0064);
      apb(0, `OFF_MAX_FLOW, 0); check(q, 32'h0000_1770);
      apb(1, `OFF_CTRL, 32'h0000_0001);
      apb(1, `OFF_CTRL, 32'h0000_0002);
      wait_cycles(1);
      check(pump_run, 1'b0);
      apb(0, `OFF_STATUS, 0); check(q[1:0], 32'h0000_0000);
      slow <= 1'b0;
   endtask : calibrate

   task automatic loop_scaling;
      apb(1, `OFF_FLOW_SET, 32'h0000_0BB8);
      apb(1, `OFF_HIGH_FLOW, 32'h0000_07D0);
      apb(1, `OFF_CTRL, 32'h0000_0004);
      level_ua <= 16'h2EE0;
      wait_cycles(3);
      check(flow_setpoint, 32'h0000_03E8);
      @(posedge pclk);
      level_ua <= 16'h07D0;
      wait_cycles(3);
      check(flow_setpoint, 32'h0000_0000);
      @(posedge pclk);
      level_ua <= 16'h61A8;
      wait_cycles(3);
      check(flow_setpoint, 32'h0000_07D0);
      apb(1, `OFF_FLOW_SET, 32'h0000_0010);
      apb(0, `OFF_FLOW_SET, 0); check(q, 32'h0000_0BB8);
      apb(1, `OFF_HIGH_MA, 32'h0000_0FA0);
      apb(1, `OFF_LOW_FLOW, 32'h0000_0020);
      wait_cycles(3);
      check(flow_setpoint, 32'h0000_0020);
      apb(1, `OFF_CTRL, 32'h0000_0024);
      wait_cycles(3);
      check(flow_setpoint, 32'h0000_0BB8);
      apb(1, `OFF_HIGH_MA, 32'h0000_4E20);
      apb(1, `OFF_LOW_FLOW, 32'h0000_0000);
   endtask : loop_scaling

   task automatic speed_output;
      apb(1, `OFF_CTRL, 32'h0000_0008);
      wait_cycles(3);
      check(speed_code, 32'h0000_09C4);
      apb(1, `OFF_FLOW_SET, 32'h0000_2000);
      wait_cycles(3);
      check(speed_code, 32'h0000_1388);
      apb(1, `OFF_CTRL, 32'h0000_010C);
      apb(1, `OFF_INJ_EN, 32'h0000_0005);
      level_ua <= 16'h2EE0;
      wait_cycles(3);
      check(speed_code, 32'h0000_0341);
      check({inj_rate[0], inj_rate[2]}, 32'h03E8_03E8);
      check({inj_rate[1], inj_rate[7]}, 32'h0000_0000);
      apb(1, `OFF_CTRL, 32'h0000_0038);
      wait_cycles(3);
      check(speed_code, 32'h0000_0000);
      check(metric_units, 1'b1);
   endtask : speed_output

   task automatic complete_run;
      $display("checks=%0d failures=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   initial begin
      #100us;
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      calibrate();
      loop_scaling();
      speed_output();
      complete_run();
   end
endmodule : flow_scaling_and_calibration_tb
